// file: hw/sio_cfg_bank.sv
// Configuration register bank with index/data ports and four reset sources
`timescale 1ns/100ps
`default_nettype none
`include "sio_cfg_regs.svh"

module sio_cfg_bank
   import sio_cfg_pkg::*;
#(
   parameter logic [7:0] PART_ID = 8'ha5,  // Arbitrary value
   parameter logic [7:0] SILICON_REV = 8'h01,  // Arbitrary value
   parameter int POR_BLOCK_CYC = `SIO_POR_BLOCK_CYC
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic standby_supply_power_on_reset,
   input wire logic host_bus_reset_pin_n,
   input wire logic base_select_strap,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rvalid,
   output logic cfg_mode,
   output logic [7:0] ldev_select
);
   sio_state_reg_t s_r;
   sio_state_reg_t s_nxt;
   logic [1:0] hard_sync_r;
   logic [1:0] stby_sync_r;
   logic [1:0] strap_sync_r;
   logic [15:0] port_base;
   logic at_index;
   logic at_data;
   logic hard_edge;
   logic stby_edge;
   logic [7:0] rd_mux;
   logic [1:0] pwr_stby_r;
   logic pwr_wr;

   // Pin inputs cross two flops before any logic looks at them
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hard_sync_r <= 2'h0;
         stby_sync_r <= 2'h0;
         strap_sync_r <= 2'h0;
      end else begin
         hard_sync_r <= {hard_sync_r[0], ~host_bus_reset_pin_n};
         stby_sync_r <= {stby_sync_r[0], standby_supply_power_on_reset};
         strap_sync_r <= {strap_sync_r[0], base_select_strap};
      end
   end

   assign port_base = {s_r.port_hi, s_r.port_lo};
   assign at_index = (io_addr == port_base);
   assign at_data = (io_addr == port_base + 16'h0001) && (s_r.st == SIO_ST_CFG);
   assign hard_edge = hard_sync_r[1] & ~s_r.hard_d;
   assign stby_edge = stby_sync_r[1] & ~s_r.stby_d;

   // Bits 7 and 5 of power control live outside the struct: only the standby
   // reset may clear them, so they carry no main-supply reset at all
   assign pwr_wr = !s_r.blocked && io_wr && !io_rd && at_data && !hard_edge
      && !s_r.soft_pend && s_r.index == `SIO_IDX_PWR_CTRL;

   always_ff @(posedge mclk) begin
      if (stby_edge) begin
         pwr_stby_r <= 2'h0;
      end else if (pwr_wr) begin
         pwr_stby_r <= {io_wdata[7], io_wdata[5]};
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      if (s_r.index < `SIO_IDX_ACTIVATE) begin
         case (s_r.index)
            `SIO_IDX_RSVD_03: rd_mux = 8'h00;
            `SIO_IDX_LDEV_SEL: rd_mux = s_r.ldev;
            `SIO_IDX_PART_ID: rd_mux = PART_ID;
            `SIO_IDX_SI_REV: rd_mux = SILICON_REV;
            `SIO_IDX_PWR_CTRL: begin
               rd_mux = {pwr_stby_r[1], s_r.pwr_ctrl[6], pwr_stby_r[0], s_r.pwr_ctrl[4:0]};
            end
            `SIO_IDX_PWR_MGMT: rd_mux = s_r.pwr_mgmt;
            `SIO_IDX_OSC_CTRL: rd_mux = s_r.osc;
            `SIO_IDX_PORT_LO: rd_mux = s_r.port_lo;
            `SIO_IDX_PORT_HI: rd_mux = s_r.port_hi;
            default: begin
               if (s_r.index >= `SIO_IDX_TEST_BASE) begin
                  rd_mux = s_r.test[(s_r.index[2:0] - 3'h2) * 8 +: 8];
               end
            end
         endcase
      end else if (s_r.ldev == `SIO_LDEV_FLOPPY) begin
         case (s_r.index)
            `SIO_IDX_ACTIVATE: rd_mux = s_r.fd_act;
            `SIO_IDX_BASE_HI: rd_mux = s_r.fd_base_hi;
            `SIO_IDX_BASE_LO: rd_mux = s_r.fd_base_lo;
            `SIO_IDX_IRQ_SEL: rd_mux = s_r.fd_irq;
            `SIO_IDX_DMA_SEL: rd_mux = s_r.fd_dma;
            `SIO_IDX_MODE: rd_mux = s_r.fd_mode;
            `SIO_IDX_OPTION: rd_mux = s_r.fd_opt;
            `SIO_IDX_TYPE: rd_mux = s_r.fd_type;
            `SIO_IDX_DRV0: rd_mux = s_r.fd_drv0;
            `SIO_IDX_DRV1: rd_mux = s_r.fd_drv1;
            default: rd_mux = 8'h00;
         endcase
      end else if (s_r.ldev == `SIO_LDEV_PRINTER) begin
         case (s_r.index)
            `SIO_IDX_ACTIVATE: rd_mux = s_r.pp_act;
            `SIO_IDX_BASE_HI: rd_mux = s_r.pp_base_hi;
            `SIO_IDX_BASE_LO: rd_mux = s_r.pp_base_lo;
            `SIO_IDX_IRQ_SEL: rd_mux = s_r.pp_irq;
            `SIO_IDX_DMA_SEL: rd_mux = s_r.pp_dma;
            `SIO_IDX_MODE: rd_mux = s_r.pp_mode;
            default: rd_mux = 8'h00;
         endcase
      end
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.hard_d = hard_sync_r[1];
      s_nxt.stby_d = stby_sync_r[1];
      s_nxt.rvalid = 1'b0;
      s_nxt.soft_pend = 1'b0;
      if (s_r.blocked) begin
         if (s_r.block_cnt == 17'(POR_BLOCK_CYC - 1)) begin
            s_nxt.blocked = 1'b0;
         end
         // Strap has crossed its synchroniser two cycles after release
         if (s_r.block_cnt == 17'h00002) begin
            s_nxt.port_lo = strap_sync_r[1] ? `SIO_RST_PORT_LO_1 : `SIO_RST_PORT_LO_0;
         end
         s_nxt.block_cnt = s_r.block_cnt + 17'h00001;
      end else if (io_rd && at_data) begin
         s_nxt.rdata = rd_mux;
         s_nxt.rvalid = 1'b1;
      end else if (io_rd && at_index && s_r.st == SIO_ST_CFG) begin
         s_nxt.rdata = s_r.index;
         s_nxt.rvalid = 1'b1;
      end else if (io_wr && at_index) begin
         case (s_r.st)
            SIO_ST_RUN: begin
               if (io_wdata == `SIO_KEY_ENTER) begin
                  s_nxt.st = SIO_ST_CFG;
               end
            end
            SIO_ST_CFG: begin
               if (io_wdata == `SIO_KEY_EXIT) begin
                  s_nxt.st = SIO_ST_RUN;
               end else begin
                  s_nxt.index = io_wdata;
               end
            end
            default: s_nxt.st = SIO_ST_RUN;
         endcase
      end else if (io_wr && at_data) begin
         if (s_r.index < `SIO_IDX_ACTIVATE) begin
            case (s_r.index)
               `SIO_IDX_CFG_CTRL: s_nxt.soft_pend = io_wdata[`SIO_SOFT_RESET_BIT];
               `SIO_IDX_LDEV_SEL: s_nxt.ldev = io_wdata;
               `SIO_IDX_PWR_CTRL: s_nxt.pwr_ctrl = io_wdata;
               `SIO_IDX_PWR_MGMT: s_nxt.pwr_mgmt = io_wdata;
               `SIO_IDX_OSC_CTRL: s_nxt.osc = io_wdata;
               `SIO_IDX_PORT_LO: s_nxt.port_lo = io_wdata;
               `SIO_IDX_PORT_HI: s_nxt.port_hi = io_wdata;
               default: begin
                  if (s_r.index >= `SIO_IDX_TEST_BASE) begin
                     s_nxt.test[(s_r.index[2:0] - 3'h2) * 8 +: 8] = io_wdata;
                  end
               end
            endcase
         end else if (s_r.ldev == `SIO_LDEV_FLOPPY) begin
            case (s_r.index)
               `SIO_IDX_ACTIVATE: s_nxt.fd_act = io_wdata;
               `SIO_IDX_BASE_HI: s_nxt.fd_base_hi = io_wdata;
               `SIO_IDX_BASE_LO: s_nxt.fd_base_lo = io_wdata;
               `SIO_IDX_IRQ_SEL: s_nxt.fd_irq = io_wdata;
               `SIO_IDX_DMA_SEL: s_nxt.fd_dma = io_wdata;
               `SIO_IDX_MODE: s_nxt.fd_mode = io_wdata;
               `SIO_IDX_OPTION: s_nxt.fd_opt = io_wdata;
               `SIO_IDX_TYPE: s_nxt.fd_type = io_wdata;
               `SIO_IDX_DRV0: s_nxt.fd_drv0 = io_wdata;
               `SIO_IDX_DRV1: s_nxt.fd_drv1 = io_wdata;
               default: s_nxt.ldev = s_r.ldev;
            endcase
         end else if (s_r.ldev == `SIO_LDEV_PRINTER) begin
            case (s_r.index)
               `SIO_IDX_ACTIVATE: s_nxt.pp_act = io_wdata;
               `SIO_IDX_BASE_HI: s_nxt.pp_base_hi = io_wdata;
               `SIO_IDX_BASE_LO: s_nxt.pp_base_lo = io_wdata;
               `SIO_IDX_IRQ_SEL: s_nxt.pp_irq = io_wdata;
               `SIO_IDX_DMA_SEL: s_nxt.pp_dma = io_wdata;
               `SIO_IDX_MODE: s_nxt.pp_mode = io_wdata;
               default: s_nxt.ldev = s_r.ldev;
            endcase
         end
      end
      // Soft reset: one cycle after the write, bit is never stored
      if (s_r.soft_pend) begin
         s_nxt.ldev = 8'h00;
         s_nxt.pwr_ctrl = s_r.pwr_ctrl & `SIO_PWR_STBY_MASK;
         s_nxt.fd_act = 8'h00;
         s_nxt.fd_base_hi = `SIO_RST_FD_BASE_HI;
         s_nxt.fd_base_lo = `SIO_RST_FD_BASE_LO;
         s_nxt.fd_irq = `SIO_RST_FD_IRQ;
         s_nxt.fd_dma = `SIO_RST_FD_DMA;
         s_nxt.pp_act = 8'h00;
         s_nxt.pp_base_hi = 8'h00;
         s_nxt.pp_base_lo = 8'h00;
         s_nxt.pp_irq = 8'h00;
         s_nxt.pp_dma = `SIO_RST_PP_DMA;
      end
      // Hard and standby resets share the full column; they differ in a few fields
      if (hard_edge || stby_edge) begin
         s_nxt.st = SIO_ST_RUN;
         s_nxt.index = 8'h00;
         s_nxt.soft_pend = 1'b0;
         s_nxt.ldev = 8'h00;
         s_nxt.pwr_mgmt = 8'h00;
         s_nxt.osc = `SIO_RST_OSC;
         s_nxt.fd_act = 8'h00;
         s_nxt.fd_base_hi = `SIO_RST_FD_BASE_HI;
         s_nxt.fd_base_lo = `SIO_RST_FD_BASE_LO;
         s_nxt.fd_irq = `SIO_RST_FD_IRQ;
         s_nxt.fd_dma = `SIO_RST_FD_DMA;
         s_nxt.fd_mode = `SIO_RST_FD_MODE;
         s_nxt.fd_opt = 8'h00;
         s_nxt.fd_type = `SIO_RST_FD_TYPE;
         s_nxt.fd_drv0 = 8'h00;
         s_nxt.fd_drv1 = 8'h00;
         s_nxt.pp_act = 8'h00;
         s_nxt.pp_base_hi = 8'h00;
         s_nxt.pp_base_lo = 8'h00;
         s_nxt.pp_irq = 8'h00;
         s_nxt.pp_dma = `SIO_RST_PP_DMA;
         s_nxt.pp_mode = `SIO_RST_PP_MODE;
         s_nxt.pwr_ctrl = stby_edge ? 8'h00 : (s_r.pwr_ctrl & `SIO_PWR_STBY_MASK);
      end
      if (hard_edge) begin
         s_nxt.port_lo = strap_sync_r[1] ? `SIO_RST_PORT_LO_1 : `SIO_RST_PORT_LO_0;
         s_nxt.port_hi = 8'h00;
      end
      if (stby_edge) begin
         s_nxt.test = 48'h0;
      end
   end

   // Reset by rstn is the main-supply power-on reset
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
         s_r.st <= SIO_ST_RUN;
         s_r.blocked <= 1'b1;
         s_r.osc <= `SIO_RST_OSC;
         s_r.port_lo <= `SIO_RST_PORT_LO_0;
         s_r.fd_base_hi <= `SIO_RST_FD_BASE_HI;
         s_r.fd_base_lo <= `SIO_RST_FD_BASE_LO;
         s_r.fd_irq <= `SIO_RST_FD_IRQ;
         s_r.fd_dma <= `SIO_RST_FD_DMA;
         s_r.fd_mode <= `SIO_RST_FD_MODE;
         s_r.fd_type <= `SIO_RST_FD_TYPE;
         s_r.pp_dma <= `SIO_RST_PP_DMA;
         s_r.pp_mode <= `SIO_RST_PP_MODE;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         io_rdata <= 8'h00;
         io_rvalid <= 1'b0;
         cfg_mode <= 1'b0;
         ldev_select <= 8'h00;
      end else begin
         io_rdata <= s_nxt.rdata;
         io_rvalid <= s_nxt.rvalid;
         cfg_mode <= (s_nxt.st == SIO_ST_CFG);
         ldev_select <= s_nxt.ldev;
      end
   end

   a_block_holds: assert property (@(posedge mclk) disable iff (!rstn)
      s_r.blocked |=> !io_rvalid && s_r.st == $past(s_r.st))
      else $error("access taken during power-on block");
   a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rstn)
      (!s_r.blocked && io_rd && at_data && s_r.index == `SIO_IDX_RSVD_03) |=> io_rdata == 8'h00)
      else $error("reserved index read non-zero");
   a_part_id: assert property (@(posedge mclk) disable iff (!rstn)
      (!s_r.blocked && io_rd && at_data && s_r.index == `SIO_IDX_PART_ID) |=> io_rdata == PART_ID)
      else $error("part code wrong");
   a_rev_fixed: assert property (@(posedge mclk) disable iff (!rstn)
      (!s_r.blocked && io_rd && at_data && s_r.index == `SIO_IDX_SI_REV) |=> io_rdata == SILICON_REV)
      else $error("revision wrong");
   a_soft_clear: assert property (@(posedge mclk) disable iff (!rstn)
      s_r.soft_pend && !hard_edge && !stby_edge |=> s_r.ldev == 8'h00 && s_r.fd_irq == 8'h06
      && !s_r.soft_pend && s_r.pp_mode == $past(s_r.pp_mode))
      else $error("soft reset effect wrong");
   a_hard_port: assert property (@(posedge mclk) disable iff (!rstn)
      hard_edge |=> s_r.port_hi == 8'h00 && (s_r.port_lo == 8'h2e || s_r.port_lo == 8'h4e))
      else $error("port address not reloaded");
   a_hard_cols: assert property (@(posedge mclk) disable iff (!rstn)
      hard_edge |=> s_r.fd_base_hi == 8'h03 && s_r.fd_base_lo == 8'hf0 && s_r.pp_mode == 8'h3c)
      else $error("hard reset column wrong");
   a_pwr_keep: assert property (@(posedge mclk) disable iff (!rstn)
      (hard_edge && !stby_edge) |=> pwr_stby_r == $past(pwr_stby_r))
      else $error("standby-only bit disturbed");
   a_stby_bits: assert property (@(posedge mclk) disable iff (!rstn)
      stby_edge |=> pwr_stby_r == 2'h0)
      else $error("standby-only bits not cleared");
   a_ldev_clear: assert property (@(posedge mclk) disable iff (!rstn)
      (hard_edge || stby_edge || s_r.soft_pend) |=> s_r.ldev == 8'h00)
      else $error("device select not cleared");
   a_port_keep: assert property (@(posedge mclk) disable iff (!rstn)
      (stby_edge && !hard_edge && !io_wr) |=> s_r.port_lo == $past(s_r.port_lo)
      && s_r.port_hi == $past(s_r.port_hi))
      else $error("port address disturbed by standby reset");
   a_fd_base_rst: assert property (@(posedge mclk) disable iff (!rstn)
      (hard_edge || stby_edge || s_r.soft_pend) |=> s_r.fd_base_hi == 8'h03
      && s_r.fd_base_lo == 8'hf0)
      else $error("floppy base not reloaded");
   a_fd_irq_rst: assert property (@(posedge mclk) disable iff (!rstn)
      (hard_edge || stby_edge || s_r.soft_pend) |=> s_r.fd_irq == 8'h06)
      else $error("floppy interrupt select not reloaded");
   a_pp_mode_stby: assert property (@(posedge mclk) disable iff (!rstn)
      stby_edge |=> s_r.pp_mode == 8'h3c)
      else $error("printer mode not reloaded");
   a_data_run_off: assert property (@(posedge mclk) disable iff (!rstn)
      (!s_r.blocked && io_rd && io_addr == port_base + 16'h0001
      && s_r.st == SIO_ST_RUN) |=> !io_rvalid)
      else $error("data port answered in run state");
   a_other_dev_zero: assert property (@(posedge mclk) disable iff (!rstn)
      (!s_r.blocked && io_rd && at_data && s_r.index >= 8'h30 && s_r.ldev != 8'h00
      && s_r.ldev != 8'h03) |=> io_rvalid && io_rdata == 8'h00)
      else $error("absent device read non-zero");
   a_key_enter: assert property (@(posedge mclk) disable iff (!rstn)
      (!s_r.blocked && io_wr && at_index && io_wdata == 8'h55 && !hard_edge && !stby_edge
      && !(io_rd && at_data) && !io_rd) |=> ##1 cfg_mode)
      else $error("config key not honoured");
   c_enter: cover property (@(posedge mclk) disable iff (!rstn) $rose(cfg_mode));
   c_soft: cover property (@(posedge mclk) disable iff (!rstn) s_r.soft_pend);
   c_read: cover property (@(posedge mclk) disable iff (!rstn) io_rvalid);
   c_unblock: cover property (@(posedge mclk) disable iff (!rstn) $fell(s_r.blocked));
   c_hard: cover property (@(posedge mclk) disable iff (!rstn) hard_edge);
endmodule  // sio_cfg_bank
`default_nettype wire

// file: hw/sio_cfg_regs.svh
// Offsets, reset values and timing counts of the configuration bank
`ifndef SIO_CFG_REGS_SVH
`define SIO_CFG_REGS_SVH

`define SIO_KEY_ENTER 8'h55
`define SIO_KEY_EXIT 8'haa

`define SIO_IDX_CFG_CTRL 8'h02
`define SIO_IDX_RSVD_03 8'h03
`define SIO_IDX_LDEV_SEL 8'h07
`define SIO_IDX_PART_ID 8'h20
`define SIO_IDX_SI_REV 8'h21
`define SIO_IDX_PWR_CTRL 8'h22
`define SIO_IDX_PWR_MGMT 8'h23
`define SIO_IDX_OSC_CTRL 8'h24
`define SIO_IDX_PORT_LO 8'h26
`define SIO_IDX_PORT_HI 8'h27
`define SIO_IDX_RSVD_28 8'h28
`define SIO_IDX_TEST_BASE 8'h2a
`define SIO_IDX_TEST_LAST 8'h2f
`define SIO_IDX_ACTIVATE 8'h30
`define SIO_IDX_BASE_HI 8'h60
`define SIO_IDX_BASE_LO 8'h61
`define SIO_IDX_IRQ_SEL 8'h70
`define SIO_IDX_DMA_SEL 8'h74
`define SIO_IDX_MODE 8'hf0
`define SIO_IDX_OPTION 8'hf1
`define SIO_IDX_TYPE 8'hf2
`define SIO_IDX_DRV0 8'hf4
`define SIO_IDX_DRV1 8'hf5

`define SIO_LDEV_FLOPPY 8'h00
`define SIO_LDEV_PRINTER 8'h03

`define SIO_SOFT_RESET_BIT 0
`define SIO_PWR_STBY_MASK 8'ha0

`define SIO_RST_OSC 8'h04
`define SIO_RST_PORT_LO_0 8'h2e
`define SIO_RST_PORT_LO_1 8'h4e
`define SIO_RST_FD_BASE_HI 8'h03
`define SIO_RST_FD_BASE_LO 8'hf0
`define SIO_RST_FD_IRQ 8'h06
`define SIO_RST_FD_DMA 8'h02
`define SIO_RST_FD_MODE 8'h0e
`define SIO_RST_FD_TYPE 8'hff
`define SIO_RST_PP_DMA 8'h04
`define SIO_RST_PP_MODE 8'h3c

`define SIO_POR_BLOCK_NS 500000
`define SIO_CLK_PERIOD_NS 8
`define SIO_POR_BLOCK_CYC ((`SIO_POR_BLOCK_NS + `SIO_CLK_PERIOD_NS - 1) / `SIO_CLK_PERIOD_NS)

`endif

// file: hw/sio_cfg_pkg.sv
// Types shared by the configuration bank
package sio_cfg_pkg;
   typedef enum logic [1:0] {
      SIO_ST_RUN = 2'b01,
      SIO_ST_CFG = 2'b10
   } sio_state_t;

   typedef struct packed {
      sio_state_t st;
      logic [16:0] block_cnt;
      logic blocked;
      logic [7:0] index;
      logic [7:0] ldev;
      logic [7:0] pwr_ctrl;
      logic [7:0] pwr_mgmt;
      logic [7:0] osc;
      logic [7:0] port_lo;
      logic [7:0] port_hi;
      logic [47:0] test;
      logic [7:0] fd_act;
      logic [7:0] fd_base_hi;
      logic [7:0] fd_base_lo;
      logic [7:0] fd_irq;
      logic [7:0] fd_dma;
      logic [7:0] fd_mode;
      logic [7:0] fd_opt;
      logic [7:0] fd_type;
      logic [7:0] fd_drv0;
      logic [7:0] fd_drv1;
      logic [7:0] pp_act;
      logic [7:0] pp_base_hi;
      logic [7:0] pp_base_lo;
      logic [7:0] pp_irq;
      logic [7:0] pp_dma;
      logic [7:0] pp_mode;
      logic [7:0] rdata;
      logic rvalid;
      logic hard_d;
      logic stby_d;
      logic soft_pend;
   } sio_state_reg_t;
endpackage

// file: verif/sio_host_model.sv
// Host-side model driving the index and data ports of the bank
`timescale 1ns/100ps
`default_nettype none
module sio_host_model (
   input wire logic mclk,
   output logic io_wr,
   output logic io_rd,
   output logic [15:0] io_addr,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_rvalid
);
   logic [15:0] base = 16'h002e;
   initial begin
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_addr = 16'h0000;
      io_wdata = 8'h00;
   end
   task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(negedge mclk);
      io_addr = a;
      io_wdata = d;
      io_wr = wr;
      io_rd = !wr;
      @(negedge mclk);
      io_wr = 1'b0;
      io_rd = 1'b0;
      // Idle bus shows inverted values so a stale address never matches
      io_addr = ~a;
      io_wdata = ~d;
   endtask
   task automatic put(input logic [15:0] a, input logic [7:0] d);
      access(1'b1, a, d);
   endtask
   task automatic get(input logic [15:0] a, output logic [7:0] d, output logic ok);
      int n;
      ok = 1'b0;
      d = 8'h00;
      access(1'b0, a, 8'h00);
      for (n = 0; n < 4 && !ok; n++) begin
         if (io_rvalid === 1'b1) begin
            ok = 1'b1;
            d = io_rdata;
         end else begin
            @(negedge mclk);
         end
      end
   endtask
   task automatic key(input logic [7:0] k);
      put(base, k);
   endtask
   task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
      put(base, idx);
      put(base + 16'h0001, v);
   endtask
   task automatic rreg(input logic [7:0] idx, output logic [7:0] v, output logic ok);
      put(base, idx);
      get(base + 16'h0001, v, ok);
   endtask
endmodule  // sio_host_model
`default_nettype wire

// file: verif/tb_superio_global_config_regs.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/100ps
`default_nettype none
module tb_superio_global_config_regs;
   localparam int POR_CYC = 20;
   localparam logic [7:0] ID_V = 8'h3c;  // Arbitrary value
   localparam logic [7:0] REV_V = 8'h07;  // Arbitrary value
   // {device, index, reset value, cleared by soft/standby/hard}
   localparam logic [26:0] TBL [25] = '{
      {8'h00, 8'h22, 8'h00, 3'b111}, {8'h00, 8'h23, 8'h00, 3'b011}, {8'h00, 8'h24, 8'h04, 3'b011},
      {8'h00, 8'h2a, 8'h00, 3'b010}, {8'h00, 8'h2b, 8'h00, 3'b010}, {8'h00, 8'h2c, 8'h00, 3'b010},
      {8'h00, 8'h2d, 8'h00, 3'b010}, {8'h00, 8'h2e, 8'h00, 3'b010}, {8'h00, 8'h2f, 8'h00, 3'b010},
      {8'h00, 8'h30, 8'h00, 3'b111}, {8'h00, 8'h60, 8'h03, 3'b111}, {8'h00, 8'h61, 8'hf0, 3'b111},
      {8'h00, 8'h70, 8'h06, 3'b111}, {8'h00, 8'h74, 8'h02, 3'b111}, {8'h00, 8'hf0, 8'h0e, 3'b011},
      {8'h00, 8'hf1, 8'h00, 3'b011}, {8'h00, 8'hf2, 8'hff, 3'b011}, {8'h00, 8'hf4, 8'h00, 3'b011},
      {8'h00, 8'hf5, 8'h00, 3'b011}, {8'h03, 8'h30, 8'h00, 3'b111}, {8'h03, 8'h60, 8'h00, 3'b111},
      {8'h03, 8'h61, 8'h00, 3'b111}, {8'h03, 8'h70, 8'h00, 3'b111}, {8'h03, 8'h74, 8'h04, 3'b111},
      {8'h03, 8'hf0, 8'h3c, 3'b011}};
   // {device, index, expected read after writing all ones}
   localparam logic [23:0] FIX [6] = '{{8'h00, 8'h03, 8'h00}, {8'h00, 8'h20, ID_V},
      {8'h00, 8'h21, REV_V}, {8'h00, 8'h28, 8'h00}, {8'h00, 8'h40, 8'h00}, {8'h01, 8'h30, 8'h00}};
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic stby = 1'b0;
   logic hrst_n = 1'b1;
   logic strap = 1'b0;
   logic io_wr, io_rd, io_rvalid, cfg_mode;
   logic [15:0] io_addr;
   logic [7:0] io_wdata, io_rdata, ldev_select;
   int err_count = 0;
   int total_checks = 0;

   always #4 mclk = ~mclk;

   sio_cfg_bank #(
      .PART_ID(ID_V),
      .SILICON_REV(REV_V),
      .POR_BLOCK_CYC(POR_CYC)
   ) u_dut (
      .mclk(mclk),
      .rstn(rstn),
      .standby_supply_power_on_reset(stby),
      .host_bus_reset_pin_n(hrst_n),
      .base_select_strap(strap),
      .io_wr(io_wr),
      .io_rd(io_rd),
      .io_addr(io_addr),
      .io_wdata(io_wdata),
      .io_rdata(io_rdata),
      .io_rvalid(io_rvalid),
      .cfg_mode(cfg_mode),
      .ldev_select(ldev_select)
   );

   sio_host_model u_host (
      .mclk(mclk),
      .io_wr(io_wr),
      .io_rd(io_rd),
      .io_addr(io_addr),
      .io_wdata(io_wdata),
      .io_rdata(io_rdata),
      .io_rvalid(io_rvalid)
   );

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] v;
      logic ok;
      u_host.rreg(idx, v, ok);
      chk({7'h00, ok}, 8'h01);
      chk(v, exp);
   endtask
   task automatic sel(input logic [7:0] ld);
      u_host.wreg(8'h07, ld);
   endtask
   // Kind 0 hard, 1 standby, 2 soft, 3 main power-on; ends back in config state
   task automatic do_reset(input int kind);
      repeat (4) @(negedge mclk);
      case (kind)
         0: hrst_n = 1'b0;
         1: stby = 1'b1;
         2: u_host.wreg(8'h02, 8'h01);
         default: rstn = 1'b0;
      endcase
      repeat (4) @(negedge mclk);
      hrst_n = 1'b1;
      stby = 1'b0;
      rstn = 1'b1;
      repeat (POR_CYC + 6) @(negedge mclk);
      if (kind == 0 || kind == 3) u_host.base = (kind == 0 && strap) ? 16'h004e : 16'h002e;
      u_host.key(8'h55);
      repeat (2) @(negedge mclk);
   endtask
   task automatic sweep(input int kind);
      logic [7:0] e;
      foreach (TBL[i]) begin
         sel(TBL[i][26:19]);
         u_host.wreg(TBL[i][18:11], ~TBL[i][10:3]);
      end
      do_reset(kind);
      chk(ldev_select, 8'h00);
      rchk(8'h07, 8'h00);
      rchk(8'h02, 8'h00);
      rchk(8'h20, ID_V);
      rchk(8'h21, REV_V);
      foreach (TBL[i]) begin
         e = (kind == 3 || TBL[i][kind]) ? TBL[i][10:3] : ~TBL[i][10:3];
         // Bits 7 and 5 of power control survive all but the standby reset
         if (TBL[i][18:11] == 8'h22 && kind != 1) e = 8'ha0;
         sel(TBL[i][26:19]);
         rchk(TBL[i][18:11], e);
      end
   endtask
   task automatic t_block();
      u_host.key(8'h55);
      repeat (3) @(negedge mclk);
      chk({7'h00, cfg_mode}, 8'h00);
      repeat (POR_CYC) @(negedge mclk);
      u_host.key(8'h55);
      repeat (3) @(negedge mclk);
      chk({7'h00, cfg_mode}, 8'h01);
   endtask
   task automatic t_fixed();
      foreach (FIX[i]) begin
         sel(FIX[i][23:16]);
         u_host.wreg(FIX[i][15:8], 8'hff);
         rchk(FIX[i][15:8], FIX[i][7:0]);
      end
      sel(8'h00);
   endtask
   task automatic t_port();
      u_host.wreg(8'h26, 8'h60);
      u_host.base = 16'h0060;
      rchk(8'h26, 8'h60);
      u_host.wreg(8'h27, 8'h01);
      u_host.base = 16'h0160;
      rchk(8'h27, 8'h01);
      for (int k = 1; k < 3; k++) begin
         do_reset(k);
         rchk(8'h26, 8'h60);
         rchk(8'h27, 8'h01);
      end
      strap = 1'b1;
      do_reset(0);
      rchk(8'h26, 8'h4e);
      rchk(8'h27, 8'h00);
      strap = 1'b0;
      do_reset(0);
      rchk(8'h26, 8'h2e);
   endtask
   task automatic t_exit();
      logic [7:0] v;
      logic ok;
      u_host.key(8'haa);
      repeat (3) @(negedge mclk);
      chk({7'h00, cfg_mode}, 8'h00);
      u_host.rreg(8'h20, v, ok);
      chk({7'h00, ok}, 8'h00);
   endtask
   task automatic conclude();
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(negedge mclk);
      rstn = 1'b1;
      t_block();
      t_fixed();
      for (int k = 0; k < 4; k++) sweep(k);
      t_port();
      t_exit();
      conclude();
   end
   // Whole run is a few thousand cycles; this margin only catches a hang
   initial begin
      repeat (40000) @(posedge mclk);
      err_count++;
      conclude();
   end
endmodule  // tb_superio_global_config_regs
`default_nettype wire
